// [hw/octal_cmd_regs.vh]
// Purpose: constants for the octal register-command decoder
// Assumes: octal-mode commands are a byte followed by its complement
// Notes: opcodes, field positions and cycle counts live here; status byte layout and program length are fixed in the decoder
`ifndef OCTAL_CMD_REGS_VH
`define OCTAL_CMD_REGS_VH
`define OP_SEC_RD 8'h2B
`define OP_SEC_WR 8'h2F
`define OP_BOOT_RD 8'h16
`define OP_BOOT_WR 8'h17
`define OP_BOOT_ER 8'h18
`define OP_OTP_IN 8'hB1
`define OP_OTP_OUT 8'hC1
`define OP_PASS_RD 8'h27
`define OP_PASS_WR 8'h28
`define OP_PASS_UL 8'h29
`define OP_CFG2_RD 8'h71
`define OP_CFG2_WR 8'h72
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_CFG_RD 8'h15
`define OP_WR_ALLOW 8'h06
`define OP_WR_DENY 8'h04
`define OP_RST_ARM 8'h66
`define OP_RST_GO 8'h99
`define OP_PLOCK_RD 8'hE2
`define OP_DLOCK_RD 8'hE0
`define OP_PROG 8'h12
`define OP_SECT_ER 8'h21
`define OP_BLK_ER 8'hDC
`define OP_CHIP_ER 8'h60
`define OP_CHIP_ER2 8'hC7
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define STATUS_RESET 8'h00
`define FIXED_DUMMY 5'h04
`define PASS_DUMMY 5'h14
`define LOCK_DUMMY_MIN 5'h06
`define LOCK_DUMMY_MAX 5'h14
`define ADDR_BYTES 3'h4
`define PASS_BYTES 4'h8
`define BOOT_WR_BYTES 4'h4
`define BOOT_RD_MAX 4'h4
`define OP_TIME_NS 1000
`define CLK_NS 4
`define OP_CYCLES ((`OP_TIME_NS) / (`CLK_NS))
`define SEC_BYTES 5'h08
`endif

// [hw/reg_store.v]
// Purpose: small register memory for security, boot and password bytes
// Assumes: one write port, one registered read port
// Notes: 32 entries of 8 bits, read data from a flip-flop
`timescale 1ns/1ps
module reg_store (
    input wire clk_sys,
    input wire reset_n,
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [4:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:31];
    integer i;

    // array kept in reset so reads before any write are defined
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 32; i = i + 1) begin
                mem[i] <= 8'h00;
            end
            rd_data <= 8'h00;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule // reg_store

// [hw/octal_register_command_decoder.v]
// Purpose: decode octal register-access commands and keep the status register
// Assumes: host presents one bus byte per cycle with byte_valid; frame ends at cs_n high
// Notes: array operations are modelled only by a busy timer
`timescale 1ns/1ps
`include "octal_cmd_regs.vh"
module octal_register_command_decoder #(
    parameter OP_CYCLES = `OP_CYCLES
) (
    input wire clk_sys,
    input wire reset_n,
    input wire cs_n,
    input wire byte_valid,
    input wire [7:0] bus_in,
    input wire double_rate,
    input wire [2:0] dummy_setting,
    output reg [7:0] bus_out,
    output reg bus_oe,
    output reg out_double_rate,
    output reg [7:0] status_flags,
    output reg otp_mode,
    output reg mem_reset,
    output reg cmd_reject
);
    localparam S_OP1 = 3'h0;
    localparam S_OP2 = 3'h1;
    localparam S_ADDR = 3'h2;
    localparam S_DUMMY = 3'h3;
    localparam S_DATA = 3'h4;
    localparam S_IGNORE = 3'h5;

    reg [2:0] state_q;
    reg [7:0] op_q;
    reg [2:0] addr_cnt_q;
    reg [4:0] dummy_cnt_q;
    reg [3:0] data_cnt_q;
    reg [3:0] data_len_q;
    reg [7:0] addr_lsb_q;
    reg reset_armed_q;
    reg [31:0] busy_cnt_q;
    reg [1:0] pend_q;
    reg busy_flag;
    reg write_allow_latch;
    reg [3:0] protect_q;
    reg [3:0] protect_pending_q;
    reg [7:0] prot_addr_q;
    reg cs_prev_q;

    wire [7:0] st_read;
    wire [4:0] lock_dummy;
    wire [7:0] store_q;
    reg store_we;
    reg [4:0] store_waddr;
    reg [4:0] store_raddr;
    reg has_addr;
    reg [4:0] dummy_need;
    reg [3:0] data_need;
    reg is_read;
    reg is_array;
    reg single_only;

    assign st_read = {2'b00, protect_q, write_allow_latch, busy_flag};
    // lock reads scale dummy by setting, clamped to the legal window
    assign lock_dummy = (`LOCK_DUMMY_MIN + {dummy_setting, 1'b0} > `LOCK_DUMMY_MAX) ?
        `LOCK_DUMMY_MAX : (`LOCK_DUMMY_MIN + {1'b0, dummy_setting, 1'b0});

    // per-opcode phase table
    always @* begin
        has_addr = 1'b0;
        dummy_need = 5'h00;
        data_need = 4'h0;
        is_read = 1'b0;
        is_array = 1'b0;
        single_only = 1'b0;
        case (op_q)
            `OP_SEC_RD: begin has_addr = 1'b1; dummy_need = `FIXED_DUMMY; data_need = 4'h1;
                is_read = 1'b1; end
            `OP_SEC_WR: begin end
            `OP_BOOT_RD: begin has_addr = 1'b1; dummy_need = `FIXED_DUMMY;
                data_need = `BOOT_RD_MAX; is_read = 1'b1; single_only = 1'b1; end
            `OP_BOOT_WR: begin has_addr = 1'b1; data_need = `BOOT_WR_BYTES; end
            `OP_BOOT_ER: begin end
            `OP_OTP_IN, `OP_OTP_OUT: begin end
            `OP_PASS_RD: begin has_addr = 1'b1; dummy_need = `PASS_DUMMY;
                data_need = `PASS_BYTES; is_read = 1'b1; end
            `OP_PASS_WR, `OP_PASS_UL: begin has_addr = 1'b1; data_need = `PASS_BYTES; end
            `OP_CFG2_RD, `OP_STAT_RD, `OP_CFG_RD: begin has_addr = 1'b1;
                dummy_need = `FIXED_DUMMY; data_need = 4'h1; is_read = 1'b1; end
            `OP_CFG2_WR, `OP_STAT_WR: begin has_addr = 1'b1; data_need = 4'h1; end
            `OP_PLOCK_RD, `OP_DLOCK_RD: begin has_addr = 1'b1; dummy_need = lock_dummy;
                data_need = 4'h1; is_read = 1'b1; end
            `OP_PROG: begin has_addr = 1'b1; data_need = 4'hF; is_array = 1'b1; end
            `OP_SECT_ER, `OP_BLK_ER: begin has_addr = 1'b1; is_array = 1'b1; end
            `OP_CHIP_ER, `OP_CHIP_ER2: begin is_array = 1'b1; end
            default: begin end
        endcase
    end

    // store addressing: security at 0, boot at 1-4, password at 8-15
    always @* begin
        store_we = 1'b0;
        store_waddr = 5'h00;
        store_raddr = 5'h00;
        case (op_q)
            `OP_BOOT_WR: begin store_we = (state_q == S_DATA) && byte_valid;
                store_waddr = 5'h01 + {1'b0, data_cnt_q}; end
            `OP_PASS_WR: begin store_we = (state_q == S_DATA) && byte_valid;
                store_waddr = `SEC_BYTES + {1'b0, data_cnt_q}; end
            default: begin end
        endcase
        case (op_q)
            `OP_BOOT_RD: store_raddr = 5'h01 + {1'b0, data_cnt_q};
            `OP_PASS_RD: store_raddr = `SEC_BYTES + {1'b0, data_cnt_q};
            default: store_raddr = 5'h00;
        endcase
    end

    reg_store u_store (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(store_we),
        .wr_addr(store_waddr),
        .wr_data(bus_in),
        .rd_addr(store_raddr),
        .rd_data(store_q)
    );

    // frame decode, phase counting and status keeping
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_OP1;
            op_q <= 8'h00;
            addr_cnt_q <= 3'h0;
            dummy_cnt_q <= 5'h00;
            data_cnt_q <= 4'h0;
            data_len_q <= 4'h0;
            addr_lsb_q <= 8'h00;
            reset_armed_q <= 1'b0;
            busy_cnt_q <= 32'h0;
            pend_q <= 2'b00;
            busy_flag <= 1'b0;
            write_allow_latch <= 1'b0;
            protect_q <= 4'h0;
            protect_pending_q <= 4'h0;
            prot_addr_q <= 8'h00;
            cs_prev_q <= 1'b1;
            bus_out <= 8'h00;
            bus_oe <= 1'b0;
            out_double_rate <= 1'b0;
            status_flags <= `STATUS_RESET;
            otp_mode <= 1'b0;
            mem_reset <= 1'b0;
            cmd_reject <= 1'b0;
        end else begin
            cs_prev_q <= cs_n;
            mem_reset <= 1'b0;
            cmd_reject <= 1'b0;
            status_flags <= st_read;
            // busy timer; completion lands the deferred effects
            if (busy_flag) begin
                if (busy_cnt_q == 32'h0) begin
                    busy_flag <= 1'b0;
                    write_allow_latch <= 1'b0;
                    if (pend_q == 2'b10) begin
                        protect_q <= protect_pending_q;
                    end
                    pend_q <= 2'b00;
                end else begin
                    busy_cnt_q <= busy_cnt_q - 32'h1;
                end
            end
            if (cs_n) begin
                // frame end: commit status writes that got a data byte, and array commands once past the pair
                if (!cs_prev_q && (state_q == S_DATA || state_q == S_OP2 ||
                    state_q == S_ADDR) && !busy_flag) begin
                    if (op_q == `OP_STAT_WR && write_allow_latch && data_len_q != 4'h0) begin
                        busy_flag <= 1'b1;
                        busy_cnt_q <= OP_CYCLES[31:0];
                        pend_q <= 2'b10;
                    end else if (is_array && state_q != S_OP2) begin
                        if (!write_allow_latch) begin
                            cmd_reject <= 1'b1;
                        end else if (((op_q == `OP_CHIP_ER || op_q == `OP_CHIP_ER2) &&
                            protect_q != 4'h0) || (protect_q != 4'h0 &&
                            prot_addr_q[7:4] >= (4'hF - protect_q))) begin
                            write_allow_latch <= 1'b0;
                            cmd_reject <= 1'b1;
                        end else begin
                            busy_flag <= 1'b1;
                            busy_cnt_q <= OP_CYCLES[31:0];
                            pend_q <= 2'b01;
                        end
                    end
                end
                state_q <= S_OP1;
                bus_oe <= 1'b0;
                addr_cnt_q <= 3'h0;
                dummy_cnt_q <= 5'h00;
                data_cnt_q <= 4'h0;
                data_len_q <= 4'h0;
            end else if (byte_valid || state_q == S_DUMMY || (state_q == S_DATA && is_read)) begin
                case (state_q)
                    S_OP1: begin
                        op_q <= bus_in;
                        state_q <= S_OP2;
                    end
                    S_OP2: begin
                        if (bus_in != ~op_q) begin
                            cmd_reject <= 1'b1;
                            state_q <= S_IGNORE;
                        end else if (busy_flag && op_q != `OP_STAT_RD) begin
                            state_q <= S_IGNORE;
                        end else begin
                            // reset pair must be back to back
                            reset_armed_q <= (op_q == `OP_RST_ARM);
                            if (op_q == `OP_RST_GO && reset_armed_q) begin
                                mem_reset <= 1'b1;
                                write_allow_latch <= 1'b0;
                                otp_mode <= 1'b0;
                            end
                            if (op_q == `OP_WR_ALLOW) write_allow_latch <= 1'b1;
                            if (op_q == `OP_WR_DENY) write_allow_latch <= 1'b0;
                            if (op_q == `OP_OTP_IN) otp_mode <= 1'b1;
                            if (op_q == `OP_OTP_OUT) otp_mode <= 1'b0;
                            // bare commands park in data so frame end knows the pair was whole
                            if (has_addr) state_q <= S_ADDR;
                            else state_q <= S_DATA;
                        end
                    end
                    S_ADDR: begin
                        addr_cnt_q <= addr_cnt_q + 3'h1;
                        if (addr_cnt_q == 3'h1) prot_addr_q <= bus_in;
                        if (addr_cnt_q == `ADDR_BYTES - 3'h1) begin
                            addr_lsb_q <= bus_in;
                            if (dummy_need != 5'h00) state_q <= S_DUMMY;
                            else state_q <= S_DATA;
                        end
                    end
                    S_DUMMY: begin
                        dummy_cnt_q <= dummy_cnt_q + 5'h01;
                        if (dummy_cnt_q == dummy_need - 5'h01) begin
                            state_q <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (is_read) begin
                            bus_oe <= 1'b1;
                            // restricted reads always leave at single rate
                            out_double_rate <= double_rate && !single_only;
                            bus_out <= (op_q == `OP_STAT_RD) ? st_read :
                                (op_q == `OP_CFG2_RD) ? {7'h00, addr_lsb_q[0]} : store_q;
                            if (data_cnt_q != data_need - 4'h1) data_cnt_q <= data_cnt_q + 4'h1;
                        end else if (data_cnt_q != data_need) begin
                            data_cnt_q <= data_cnt_q + 4'h1;
                            data_len_q <= data_len_q + 4'h1;
                            if (op_q == `OP_STAT_WR && data_cnt_q == 4'h0) begin
                                protect_pending_q <= bus_in[`ST_BP_HI:`ST_BP_LO];
                            end
                        end
                    end
                    S_IGNORE: begin end
                    default: state_q <= S_OP1;
                endcase
            end
        end
    end
endmodule // octal_register_command_decoder

// [tb/host_model.sv]
// Purpose: host side of the octal bus, sends whole command frames
// Assumes: one bus byte per clock, frame closed by cs_n high
// Notes: released bus lines toggle so stale bytes never look valid
`timescale 1ns/1ps
module host_model (
    input wire clk_sys,
    output reg cs_n,
    output reg byte_valid,
    output reg [7:0] bus_in,
    output reg double_rate
);
    reg [31:0] adr;
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        byte_valid = 1'b0;
        bus_in = 8'h5A;
        double_rate = 1'b0;
        adr = 32'h0;
    end
    // one clock of the frame; a non-valid clock shows a changing pattern
    task put(input logic [7:0] b, input logic v);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        byte_valid <= v;
        bus_in <= v ? b : ~bus_in;
    endtask
    // pair, address, dummy plus read wait, then write data
    task frame(input logic [7:0] op, input logic bad, input int na, input int nd,
               input int nw, input logic [63:0] d, input int nr);
        int i;
        begin
            put(op, 1'b1);
            put(bad ? op : ~op, 1'b1);
            for (i = 0; i < na; i++) put(adr[31 - 8 * i -: 8], 1'b1);
            for (i = 0; i < nd + nr; i++) put(8'h00, 1'b0);
            for (i = 0; i < nw; i++) put(d[8 * i +: 8], 1'b1);
            @(posedge clk_sys);
            cs_n <= 1'b1;
            byte_valid <= 1'b0;
            bus_in <= ~bus_in;
            // second high clock keeps frames apart
            @(posedge clk_sys);
            bus_in <= ~bus_in;
        end
    endtask
endmodule // host_model

// [tb/decoder_checker.sv]
// Purpose: port-level checks of the octal register command decoder
// Assumes: status_flags mirrors busy, latch and protect bits
// Notes: busy length counted in helper logic, not by repetition
`timescale 1ns/1ps
module decoder_checker #(
    parameter OP_CYCLES = 250
) (
    input wire clk_sys,
    input wire reset_n,
    input wire cs_n,
    input wire byte_valid,
    input wire [7:0] bus_in,
    input wire double_rate,
    input wire [2:0] dummy_setting,
    input wire [7:0] bus_out,
    input wire bus_oe,
    input wire out_double_rate,
    input wire [7:0] status_flags,
    input wire otp_mode,
    input wire mem_reset,
    input wire cmd_reject
);
    reg [15:0] busy_cnt_q;
    // length of the current busy stretch
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= status_flags[0] ? busy_cnt_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_reserved_zero: assert property (status_flags[7:6] == 2'b00)
        else $error("reserved status bits set");
    a_reject_pulse: assert property (cmd_reject |=> !cmd_reject)
        else $error("reject pulse too long");
    a_reset_pair_seen: assert property ($rose(mem_reset) |->
        !$past(cs_n) && $past(bus_in, 2) == 8'h99 ##1 !mem_reset)
        else $error("memory reset without reset-execute pair");
    a_latch_when_idle: assert property ($rose(status_flags[1]) |-> !status_flags[0])
        else $error("latch set while busy");
    a_busy_needs_latch: assert property ($rose(status_flags[0]) |-> status_flags[1])
        else $error("busy without write latch");
    a_busy_length: assert property ($fell(status_flags[0]) |-> busy_cnt_q == OP_CYCLES + 1)
        else $error("busy length wrong");
    a_protect_source: assert property (!$stable(status_flags[5:2]) |->
        $past(status_flags[0]) || $past(status_flags[0], 2))
        else $error("protect bits changed without status write");
    a_oe_in_frame: assert property (bus_oe |-> !$past(cs_n, 2))
        else $error("read data outside frame");
    a_otp_in_frame: assert property ($changed(otp_mode) |-> !$past(cs_n))
        else $error("secured area mode changed outside a frame");
endmodule // decoder_checker
bind octal_register_command_decoder decoder_checker #(.OP_CYCLES(OP_CYCLES)) i_decoder_checker (
    .clk_sys, .reset_n, .cs_n, .byte_valid, .bus_in, .double_rate, .dummy_setting,
    .bus_out, .bus_oe, .out_double_rate, .status_flags, .otp_mode, .mem_reset, .cmd_reject
);

// [tb/tb.sv]
// Purpose: self-checking bench of the octal register command decoder
// Assumes: status seen through status read frames, pulses counted per edge
// Notes: busy shortened to 40 cycles to keep the run brief
`timescale 1ns/1ps
module tb;
    localparam int P = 40;
    logic clk_sys, reset_n, oe_q;
    logic [2:0] dummy_setting;
    logic [3:0] bp;
    logic [21:0] e;
    logic [21:0] exp_q[$];
    logic [7:0] rop[5] = '{8'h16, 8'h2B, 8'h71, 8'h27, 8'hE2};
    logic [7:0] wop[4] = '{8'h2F, 8'h17, 8'h18, 8'h28};
    int rdm[5] = '{4, 4, 4, 20, 6};
    int rnr[5] = '{3, 3, 3, 10, 3};
    int wn[4] = '{0, 4, 0, 8};
    int n_mismatch, num_checks, n_rej, n_rst, seed, i, cyc_q;
    wire cs_n, byte_valid, double_rate, bus_oe, out_double_rate, otp_mode, mem_reset, cmd_reject;
    wire [7:0] bus_in, bus_out, status_flags;
    octal_register_command_decoder #(.OP_CYCLES(P)) i_octal_register_command_decoder (
        .clk_sys, .reset_n, .cs_n, .byte_valid, .bus_in, .double_rate, .dummy_setting,
        .bus_out, .bus_oe, .out_double_rate, .status_flags, .otp_mode, .mem_reset, .cmd_reject
    );
    host_model i_host_model (.clk_sys, .cs_n, .byte_valid, .bus_in, .double_rate);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task fail(input string m);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    // only opcodes of the command set are ever sent
    task frm(input logic [7:0] op, input int na, input int nw, input logic [63:0] d);
        i_host_model.frame(op, 1'b0, na, 0, nw, d, 0);
    endtask
    task rd_stat(input logic [7:0] x, input logic [7:0] m);
        exp_q.push_back({5'h04, 1'b0, m, x});
        i_host_model.frame(8'h05, 1'b0, 4, 4, 0, 0, 3);
    endtask
    // let the frame-end pulses land before counting them
    task cnt(input int r, input int s, input logic o);
        repeat (2) @(posedge clk_sys);
        num_checks++;
        if (n_rej !== r || n_rst !== s || otp_mode !== o) fail("pulse count or mode");
    endtask
    task final_report;
        if (exp_q.size() != 0) fail("read data missing");
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // oldest note against each new read burst; pulses counted
    always @(posedge clk_sys) begin
        if (bus_oe === 1'b1 && oe_q !== 1'b1) begin
            num_checks++;
            e = exp_q.pop_front();
            if (((bus_out ^ e[7:0]) & e[15:8]) !== 8'h00 ||
                out_double_rate !== e[16]) fail("read");
            // data rises one clock after the last dummy: pair, 4 address, dummy, 1
            if (cyc_q != 7 + e[21:17]) fail("dummy length");
        end
        cyc_q <= (cs_n === 1'b0) ? cyc_q + 1 : 0;
        oe_q <= bus_oe;
        if (cmd_reject === 1'b1) n_rej++;
        if (mem_reset === 1'b1) n_rst++;
    end
    initial begin
        seed = 32'h255d;
        reset_n = 1'b0;
        dummy_setting = 3'h0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        dummy_setting <= 3'($random(seed));
        repeat (2) @(posedge clk_sys);
        rdm[4] = (6 + 2 * dummy_setting > 20) ? 20 : 6 + 2 * dummy_setting;
        rd_stat(8'h00, 8'hFF);
        i_host_model.frame(8'h06, 1'b1, 0, 0, 0, 0, 0);
        cnt(1, 0, 1'b0);
        frm(8'h12, 4, 1, $random(seed));
        cnt(2, 0, 1'b0);
        rd_stat(8'h00, 8'hFF);
        frm(8'h06, 0, 0, 0);
        rd_stat(8'h02, 8'hFF);
        i_host_model.adr = $random(seed) & 32'h0000_0FFE;
        frm(8'h12, 4, 1, $random(seed));
        rd_stat(8'h03, 8'hFF);
        repeat (P + 8) @(posedge clk_sys);
        rd_stat(8'h00, 8'hFF);
        $display("test program done");
        bp = 4'($random(seed)) | 4'h1;
        i_host_model.adr = 32'h0;
        frm(8'h06, 0, 0, 0);
        frm(8'h01, 4, 1, {58'h0, bp, 2'b00});
        rd_stat(8'h01, 8'h01);
        repeat (P + 8) @(posedge clk_sys);
        rd_stat({2'b00, bp, 2'b00}, 8'hFD);
        frm(8'h06, 0, 0, 0);
        frm(8'h60, 0, 0, 0);
        cnt(3, 0, 1'b0);
        rd_stat({2'b00, bp, 2'b00}, 8'hFF);
        frm(8'h06, 0, 0, 0);
        frm(8'h01, 4, 1, 0);
        repeat (P + 8) @(posedge clk_sys);
        frm(8'h06, 0, 0, 0);
        frm(8'h60, 0, 0, 0);
        rd_stat(8'h03, 8'hFF);
        repeat (P + 8) @(posedge clk_sys);
        rd_stat(8'h00, 8'hFF);
        $display("test protect done");
        // register reads; boot read asked at double rate answers at single rate
        for (i = 0; i < 5; i++) begin
            i_host_model.double_rate <= (i == 0);
            exp_q.push_back({5'(rdm[i]), 17'h00000});
            i_host_model.frame(rop[i], 1'b0, 4, rdm[i], 0, 0, rnr[i]);
        end
        // register writes, each after write-allow and followed by a wait of P + 8 clocks; none of them starts busy
        for (i = 0; i < 4; i++) begin
            frm(8'h06, 0, 0, 0);
            frm(wop[i], (wn[i] > 0) ? 4 : 0, wn[i], {$random(seed), $random(seed)});
            repeat (P + 8) @(posedge clk_sys);
        end
        cnt(3, 0, 1'b0);
        $display("test registers done");
        frm(8'hB1, 0, 0, 0);
        cnt(3, 0, 1'b1);
        frm(8'hC1, 0, 0, 0);
        cnt(3, 0, 1'b0);
        frm(8'h66, 0, 0, 0);
        frm(8'h99, 0, 0, 0);
        cnt(3, 1, 1'b0);
        frm(8'h66, 0, 0, 0);
        frm(8'h06, 0, 0, 0);
        frm(8'h99, 0, 0, 0);
        cnt(3, 1, 1'b0);
        $display("test reset pair done");
        final_report();
    end
    // watchdog well past the expected run of about 800 cycles
    initial begin
        repeat (8000) @(posedge clk_sys);
        fail("timeout");
        final_report();
    end
endmodule // tb
